// ---- bench/tiesr_checker.sv ----
/* assertions on the ports of tiesr_top, bound into it.
   assumes one aclk domain and the synchronous aresetn. */
`timescale 1ns/1ps
module tiesr_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire tiesr_pkg::tiesr_evt_t evt,
    input wire tiesr_pkg::tiesr_req_t req,
    input wire logic irq,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [tiesr_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata
);
    logic [tiesr_pkg::ADDR_W-1:0] ar_q;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // address of the read in flight, to know which register answers
    always_ff @(posedge aclk) begin
        if (s_axi_arvalid && s_axi_arready) begin
            ar_q <= s_axi_araddr;
        end
    end
    // ************************************************************
    // properties
    // ************************************************************
    property p_rst;
        $rose(aresetn) |-> req == '0 && !irq;
    endproperty
    property p_ovf_rise;
        $rose(req.ovf) |-> $past(evt.ovf) || $rose(s_axi_bvalid);
    endproperty
    property p_chan_rise;
        |(req.chan & ~$past(req.chan)) |->
            |$past(evt.match | evt.capture) || $rose(s_axi_bvalid);
    endproperty
    // flags and enables only drop at a write's update edge
    property p_fall;
        |($past({req.ovf, req.chan}) & ~{req.ovf, req.chan}) |->
            $rose(s_axi_bvalid);
    endproperty
    property p_irq;
        $rose(|{req.ovf, req.chan}) |-> ##[1:3] irq;
    endproperty
    property p_rsvd;
        s_axi_rvalid && !ar_q[3] && ar_q[1:0] == 2'h0 |->
            s_axi_rdata[6:4] == 3'h7;
    endproperty
    property p_rsp;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    property p_wref;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    property p_rref;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_rst: assert property (p_rst) else $error("busy after reset");
    a_ovf_rise: assert property (p_ovf_rise) else $error("ovf req");
    a_chan_rise: assert property (p_chan_rise) else $error("chan req");
    a_fall: assert property (p_fall) else $error("req dropped");
    a_irq: assert property (p_irq) else $error("irq missing");
    a_rsvd: assert property (p_rsvd) else $error("reserved bits");
    a_rsp: assert property (p_rsp) else $error("read answer late");
    a_wref: assert property (p_wref) else $error("write taken early");
    a_rref: assert property (p_rref) else $error("read taken early");
    c_irq: cover property (irq);
    c_ovf: cover property (req.ovf);
    c_clr: cover property ($fell(req.chan[0]));
endmodule // tiesr_checker

bind tiesr_top tiesr_checker u_tiesr_checker (
    .aclk(aclk), .aresetn(aresetn), .evt(evt), .req(req), .irq(irq),
    .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata)
);

// ---- bench/timer_irq_enable_status_tb.sv ----
/* self-checking bench for tiesr_top through axi4-lite calls.
   assumes the checker file is compiled alongside and binds itself. */
`timescale 1ns/1ps
module timer_irq_enable_status_tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    tiesr_pkg::tiesr_evt_t evt = '0;
    tiesr_pkg::tiesr_req_t req;
    logic irq, awready, wready, bvalid, arready, rvalid;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [1:0] bresp, rresp, r;
    logic [7:0] en;
    int n_fail = 0, compares = 0, cycles = 0;

    tiesr_top u_tiesr_top (
        .aclk(aclk), .aresetn(aresetn), .evt(evt), .req(req), .irq(irq),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready)
    );

    always #2.5 aclk = ~aclk;

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic conclude();
        $display("counts: compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // address and data go out together; each drops once taken
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        chk({30'h0, bresp}, {30'h0, tiesr_pkg::RESP_OKAY});
    endtask
    task automatic rd(input logic [3:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
    endtask
    task automatic rchk(input logic [3:0] a, input logic [31:0] e);
        rd(a);
        chk(d, e);
    endtask
    task automatic pulse(input logic o, input logic [3:0] m, c);
        evt <= {o, m, c};
        @(posedge aclk);
        evt <= '0;
        repeat (3) @(posedge aclk);
    endtask

    // hang guard, well above the fewer than one hundred cycles the tests need
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            conclude();
        end
    end

    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(4'h0, 32'h70);
        rchk(4'h4, 32'h70);
        chk({27'h0, req}, 32'h0);
        $display("test reset done");
        wr(4'h0, 32'h8f);
        wr(4'h8, 32'h5);
        pulse(1'b1, 4'hf, 4'h0);
        chk({27'h0, req}, 32'h1a);
        pulse(1'b0, 4'h0, 4'hf);
        chk({27'h0, req}, 32'h1f);
        chk({31'h0, irq}, 32'h1);
        rchk(4'h8, 32'h5);
        $display("test set done");
        wr(4'h4, 32'h0);
        rchk(4'h4, 32'hff);
        wr(4'h4, 32'h0e);
        wr(4'h4, 32'h0);
        rchk(4'h4, 32'h7e);
        $display("test clear done");
        for (int i = 0; i < 5; i++) begin
            en = (i < 4) ? 8'h1 << i : 8'h80;
            wr(4'h0, {24'h0, en});
            // overflow and flag A were cleared above, so they stay low
            chk({27'h0, req}, {27'h0, 1'b0, en[3:0] & 4'he});
            rchk(4'h0, {24'h0, en | 8'h70});
        end
        wr(4'hc, 32'hff);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq}, 32'h0);
        wr(4'h0, 32'h0);
        pulse(1'b1, 4'h0, 4'h0);
        chk({27'h0, req}, 32'h0);
        wr(4'h0, 32'h80);
        repeat (2) @(posedge aclk);
        chk({27'h0, req}, 32'h10);
        chk({31'h0, irq}, 32'h1);
        rd(4'h2);
        chk({30'h0, r}, {30'h0, tiesr_pkg::RESP_SLVERR});
        $display("test gating done");
        conclude();
    end
endmodule // timer_irq_enable_status_tb

// ---- rtl/tiesr_pkg.sv ----
/*
 * package for the timer interrupt enable/status block: register offsets,
 * bit positions, reset values and the event carrier struct.
 * assumes 32-bit axi4-lite data; one register per aligned word, except the irq mask, which shares word 0 with enable.
 */
package tiesr_pkg;

    // ************************************************************
    // register map (byte addresses)
    // ************************************************************
    localparam logic [3:0] OFS_ENABLE = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_FUNC = 4'h8;
    localparam logic [3:0] OFS_IRQ_STAT = 4'hc;
    localparam logic [3:0] OFS_IRQ_MASK = 4'h0;
    localparam int ADDR_W = 4;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int BIT_OVF = 7;
    localparam int BIT_D = 3;
    localparam int BIT_C = 2;
    localparam int BIT_B = 1;
    localparam int BIT_A = 0;
    localparam int NCHAN = 4;

    localparam logic [7:0] RSVD_MASK = 8'h70;
    localparam logic [7:0] LIVE_MASK = 8'h8f;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [3:0] FUNC_RESET = 4'h0;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // strobes from the rest of the timer, one cycle each
    typedef struct packed {
        logic ovf;
        logic [3:0] match;
        logic [3:0] capture;
    } tiesr_evt_t;

    // per-source request outputs
    typedef struct packed {
        logic ovf;
        logic [3:0] chan;
    } tiesr_req_t;

endpackage

// ---- rtl/tiesr_top.sv ----
/*
 * timer interrupt enable and status flags with an axi4-lite slave.
 * holds the enable, status, function-select and sticky interrupt
 * registers, the clear-after-read sequence and the request gating.
 * assumes overflow, match and capture strobes come from timer logic
 * on the same clock as single-cycle pulses; no synchronisers needed.
 * assumes software follows the read-then-write-zero clear sequence.
 */
// The placing of the registers and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps


module tiesr_top (
    // ************************************************************
    // clock and synchronous reset
    // ************************************************************
    input wire logic aclk,
    input wire logic aresetn,
    // ************************************************************
    // strobes in, requests out
    // ************************************************************
    input wire tiesr_pkg::tiesr_evt_t evt,
    output tiesr_pkg::tiesr_req_t req,
    output logic irq,
    // ************************************************************
    // axi4-lite write address and data; prot is ignored
    // ************************************************************
    input wire logic [tiesr_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // ************************************************************
    // axi4-lite write response
    // ************************************************************
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // ************************************************************
    // axi4-lite read channels
    // ************************************************************
    input wire logic [tiesr_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // ************************************************************
    // state
    // ************************************************************
    logic [7:0] enable_q;
    logic [7:0] status_q;
    // armed_q marks flags seen at 1 by the last status read
    logic [7:0] armed_q;
    logic [3:0] func_q;
    logic [7:0] irq_mask_q;
    logic [7:0] irq_stat_q;
    logic [tiesr_pkg::ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic aw_have_q;
    logic w_have_q;
    // set_d and rise_d are the per-bit set terms of this cycle
    logic [7:0] set_d;
    logic [7:0] rise_d;

    // full-word decode shared by read and write paths; an address off
    // the word grid decodes to nothing and is answered with an error
    function automatic logic hit(
        input logic [tiesr_pkg::ADDR_W-1:0] a,
        input logic [3:0] ofs
    );
        hit = (a == ofs);
    endfunction

    // ************************************************************
    // write channel capture, either order
    // ************************************************************
    // each half waits in its holding register until the other arrives,
    // and both readies stay low while the response waits
    assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
    assign s_axi_wready = !w_have_q && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            awaddr_q <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
        end else if (aw_have_q && w_have_q) begin
            aw_have_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_have_q <= 1'b0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
        end else if (aw_have_q && w_have_q) begin
            w_have_q <= 1'b0;
        end
    end

    logic wr_go;
    logic wr_lane0;
    logic wr_ok;
    assign wr_go = aw_have_q && w_have_q;
    assign wr_lane0 = wr_go && wstrb_q[0];
    assign wr_ok = hit(awaddr_q, tiesr_pkg::OFS_ENABLE)
        || hit(awaddr_q, tiesr_pkg::OFS_STATUS)
        || hit(awaddr_q, tiesr_pkg::OFS_FUNC)
        || hit(awaddr_q, tiesr_pkg::OFS_IRQ_STAT)
        || hit(awaddr_q, tiesr_pkg::OFS_IRQ_MASK);

    // ************************************************************
    // per-register write strobes
    // ************************************************************
    // decoded once so every register sees the same qualified strobe
    logic wr_enable;
    logic wr_status;
    logic wr_func;
    logic wr_irq_stat;
    logic wr_irq_mask;
    assign wr_enable = wr_lane0 && hit(awaddr_q, tiesr_pkg::OFS_ENABLE);
    assign wr_status = wr_lane0 && hit(awaddr_q, tiesr_pkg::OFS_STATUS);
    assign wr_func = wr_lane0 && hit(awaddr_q, tiesr_pkg::OFS_FUNC);
    assign wr_irq_stat = wr_lane0 && hit(awaddr_q, tiesr_pkg::OFS_IRQ_STAT);
    assign wr_irq_mask = wr_lane0 && hit(awaddr_q, tiesr_pkg::OFS_IRQ_MASK);
    // the response follows both halves; a write off the grid is refused
    // with slverr and leaves every register untouched

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= tiesr_pkg::RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? tiesr_pkg::RESP_OKAY
                                 : tiesr_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ************************************************************
    // enable and function select
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enable_q <= tiesr_pkg::REG_RESET;
        end else if (wr_enable) begin
            // reserved bits are stored as 0 and forced to 1 on read
            enable_q <= wdata_q[7:0] & tiesr_pkg::LIVE_MASK;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            func_q <= tiesr_pkg::FUNC_RESET;
        end else if (wr_func) begin
            // 1 selects capture, 0 compare, one bit per channel
            func_q <= wdata_q[tiesr_pkg::NCHAN-1:0];
        end
    end

    // ************************************************************
    // flag set conditions
    // ************************************************************
    // a strobe held longer than one cycle sets its flag on every cycle it
    // is high, so a clear written meanwhile is overridden
    always_comb begin
        set_d = '0;
        set_d[tiesr_pkg::BIT_OVF] = evt.ovf;
    end

    genvar g;
    generate
        for (g = 0; g < tiesr_pkg::NCHAN; g++) begin : g_chan
            logic chan_set;
            assign chan_set = func_q[g] ? evt.capture[g] : evt.match[g];
            assign rise_d[g] = chan_set;
        end
    endgenerate
    // reserved bits never set; overflow has no mode select
    assign rise_d[7:4] = {set_d[7], 3'h0};

    // ************************************************************
    // status flags: read arms, zero write clears
    // ************************************************************
    // rd_take qualifies the read address for arming
    logic rd_take;
    assign rd_take = s_axi_arvalid && s_axi_arready;

    logic [7:0] clr_d;
    always_comb begin
        clr_d = '0;
        if (wr_status) begin
            // zero write on an armed flag
            clr_d = armed_q & ~wdata_q[7:0] & tiesr_pkg::LIVE_MASK;
        end
    end

    // the clear is two-step: a status read arms exactly the flags it
    // returned as 1, and the next status write may clear only those.
    // a flag set after the read is not armed, so a late event is not
    // lost to a write that software composed from stale data.
    // a read and a status write in one cycle: the read re-arms, and
    // the write clears with the old arming.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            armed_q <= '0;
        end else if (rd_take && hit(s_axi_araddr, tiesr_pkg::OFS_STATUS)) begin
            // a read that saw the flag at 1 arms its clear
            armed_q <= status_q & tiesr_pkg::LIVE_MASK;
        end else if (wr_status) begin
            armed_q <= '0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_q <= tiesr_pkg::REG_RESET;
        end else begin
            status_q <= (status_q & ~clr_d) | rise_d;
        end
    end

    // ************************************************************
    // named views of flags and enables
    // ************************************************************
    logic overflow_flag;
    logic chan_d_flag;
    logic chan_c_flag;
    logic chan_b_flag;
    logic chan_a_flag;
    logic overflow_irq_enable;
    logic chan_d_irq_enable;
    logic chan_c_irq_enable;
    logic chan_b_irq_enable;
    logic chan_a_irq_enable;
    assign overflow_flag = status_q[tiesr_pkg::BIT_OVF];
    assign chan_d_flag = status_q[tiesr_pkg::BIT_D];
    assign chan_c_flag = status_q[tiesr_pkg::BIT_C];
    assign chan_b_flag = status_q[tiesr_pkg::BIT_B];
    assign chan_a_flag = status_q[tiesr_pkg::BIT_A];
    assign overflow_irq_enable = enable_q[tiesr_pkg::BIT_OVF];
    assign chan_d_irq_enable = enable_q[tiesr_pkg::BIT_D];
    assign chan_c_irq_enable = enable_q[tiesr_pkg::BIT_C];
    assign chan_b_irq_enable = enable_q[tiesr_pkg::BIT_B];
    assign chan_a_irq_enable = enable_q[tiesr_pkg::BIT_A];

    // ************************************************************
    // requests and summary interrupt
    // ************************************************************
    // flag and enable
    assign req.ovf = overflow_flag & overflow_irq_enable;
    assign req.chan = {
        chan_d_flag & chan_d_irq_enable,
        chan_c_flag & chan_c_irq_enable,
        chan_b_flag & chan_b_irq_enable,
        chan_a_flag & chan_a_irq_enable
    };

    // the summary line follows the sticky copy, not the live requests,
    // so a short-lived request still leaves a trace for software. the
    // mask offset coincides with the enable offset, so the mask always
    // mirrors the enable bits; this costs one more cycle of latency.
    // sticky copy of raised requests, cleared by writing one
    logic [7:0] req_vec;
    logic [7:0] req_q;
    logic [7:0] w1c_d;
    assign req_vec = {req.ovf, 3'h0, req.chan};
    assign w1c_d = wr_irq_stat ? wdata_q[7:0] : 8'h00;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            req_q <= '0;
        end else begin
            req_q <= req_vec;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_q <= '0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~w1c_d) | (req_vec & ~req_q);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_mask_q <= '0;
        end else if (wr_irq_mask) begin
            irq_mask_q <= wdata_q[7:0] & tiesr_pkg::LIVE_MASK;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_q & irq_mask_q);
        end
    end

    // ************************************************************
    // read channel
    // ************************************************************
    // one read in flight: arready falls while the answer stands
    // prot carries no meaning here and every access is treated alike;
    // only byte lane 0 holds register bits, upper strobes are ignored
    // off-grid addresses answer slverr with zero data
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= tiesr_pkg::RESP_OKAY;
        end else if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= tiesr_pkg::RESP_OKAY;
            s_axi_rdata <= '0;
            if (hit(s_axi_araddr, tiesr_pkg::OFS_ENABLE)) begin
                s_axi_rdata[7:0] <= enable_q | tiesr_pkg::RSVD_MASK;
            end else if (hit(s_axi_araddr, tiesr_pkg::OFS_STATUS)) begin
                s_axi_rdata[7:0] <= status_q | tiesr_pkg::RSVD_MASK;
            end else if (hit(s_axi_araddr, tiesr_pkg::OFS_FUNC)) begin
                s_axi_rdata[tiesr_pkg::NCHAN-1:0] <= func_q;
            end else if (hit(s_axi_araddr, tiesr_pkg::OFS_IRQ_STAT)) begin
                s_axi_rdata[7:0] <= irq_stat_q;
            end else begin
                s_axi_rresp <= tiesr_pkg::RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule // tiesr_top
